// >>> design/pwt_defines.vh
`ifndef PWT_DEFINES_VH
`define PWT_DEFINES_VH
// Register byte addresses on the bus
`define PWT_OFF_CTRL 12'h000
`define PWT_OFF_RATEH 12'h004
`define PWT_OFF_RATEL 12'h008
`define PWT_OFF_TRIM_IDX 12'h2f3
`define PWT_OFF_TRIM 12'hbcc
`define PWT_OFF_STAT 12'h010
`define PWT_OFF_MASK 12'h014
// Control register fields
`define PWT_CTL_CLKSEL 7
`define PWT_CTL_WAVESEL 4
`define PWT_CTL_EXTEN 3
`define PWT_CTL_FE 2
`define PWT_CTL_IE 1
`define PWT_CTL_FLAG 0
// Trim field position
`define PWT_TRIM_LSB 2
// Reset values
`define PWT_RST_CTRL 8'h00
`define PWT_RST_RATE 8'h00
`define PWT_RST_TRIM 6'h00
// Bus responses
`define PWT_RESP_OKAY 2'b00
`define PWT_RESP_SLVERR 2'b10
`endif

// >>> design/pwt_periodic_wakeup_timer.v
`timescale 1ns/10ps
`include "pwt_defines.vh"

module pwt_periodic_wakeup_timer #(
    parameter ACLK_BASE = 1000,  // Bus cycles per autonomous tick, untrimmed (10 kHz at 10 MHz)
    parameter ACLK_STEP = 8      // Bus cycles per trim weight unit
) (
    input wire aclk,                // Bus clock, 10 MHz
    input wire aresetn,             // Synchronous reset, active low
    input wire [5:0] nvm_trim,      // Trim value held in non-volatile memory
    input wire [11:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid,       // Write address valid
    output reg s_axi_awready,       // Write address ready
    input wire [31:0] s_axi_wdata,  // Write data
    input wire [3:0] s_axi_wstrb,   // Write byte strobes
    input wire s_axi_wvalid,        // Write data valid
    output reg s_axi_wready,        // Write data ready
    output reg [1:0] s_axi_bresp,   // Write response
    output reg s_axi_bvalid,        // Write response valid
    input wire s_axi_bready,        // Write response ready
    input wire [11:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid,       // Read address valid
    output reg s_axi_arready,       // Read address ready
    output reg [31:0] s_axi_rdata,  // Read data
    output reg [1:0] s_axi_rresp,   // Read response
    output reg s_axi_rvalid,        // Read data valid
    input wire s_axi_rready,        // Read data ready
    output reg irq,                 // Level interrupt
    output reg ext_wave_pin         // External waveform output
);

// ----------------------------------------------------------------
// Register state
// ----------------------------------------------------------------
reg timer_clock_select_r;
reg ext_wave_select_r;
reg ext_output_enable_r;
reg feature_enable_r;
reg irq_enable_r;
reg timeout_flag_r;
reg [5:0] period_trim_field_r;
reg [15:0] rate_value_r;
reg [1:0] evt_status_r;   // Bit0 time-out, bit1 time-out with the autonomous clock selected
reg [1:0] evt_mask_r;
reg trim_loaded_r;

// ----------------------------------------------------------------
// Autonomous clock tick generator
// ----------------------------------------------------------------
reg [15:0] aclk_cnt_r;
reg aclk_tick_r;
wire signed [15:0] trim_sx;
wire signed [31:0] aclk_len_full;
wire [15:0] aclk_len;
// The autonomous clock is modelled as a tick enable derived from the bus clock.
// A tick lasts one bus cycle; the divider restarts whenever it reaches the
// trimmed length, so a trim change takes effect within one tick.
// signed trim weight
assign trim_sx = {{10{period_trim_field_r[5]}}, period_trim_field_r};
// sign bit lengthens, lower bits shorten
// default base gives a 10 kHz tick from a 10 MHz bus clock
assign aclk_len_full = ACLK_BASE - trim_sx * ACLK_STEP;
// Keep at least two bus cycles per tick so a large trim cannot stall the divider
assign aclk_len = (aclk_len_full < 32'sd2) ? 16'h0002 : aclk_len_full[15:0];

// Divider producing one tick per autonomous clock period
always @(posedge aclk) begin
    if (!aresetn) begin
        aclk_cnt_r <= 16'h0000;
        aclk_tick_r <= 1'b0;
    end else if (aclk_cnt_r >= aclk_len[15:0] - 16'h0001) begin
        aclk_cnt_r <= 16'h0000;
        aclk_tick_r <= 1'b1;
    end else begin
        aclk_cnt_r <= aclk_cnt_r + 16'h0001;
        aclk_tick_r <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Period counter
// ----------------------------------------------------------------
reg [16:0] per_cnt_r;
reg [16:0] per_cnt_nxt;
reg timeout_evt;
wire src_tick;
wire [16:0] per_last;
assign src_tick = timer_clock_select_r ? 1'b1 : aclk_tick_r;
assign per_last = {rate_value_r, 1'b1};
// Count runs 0 .. 2*rate+1, giving 2*(rate+1) source ticks per period.
// Rate is locked while running, so a new rate applies from the next enable.

// Next count and time-out event
always @* begin
    per_cnt_nxt = per_cnt_r;
    timeout_evt = 1'b0;
    if (!feature_enable_r) begin
        per_cnt_nxt = 17'h00000;
    end else if (src_tick) begin
        if (per_cnt_r == per_last) begin
            per_cnt_nxt = 17'h00000;
            timeout_evt = 1'b1;
        end else begin
            per_cnt_nxt = per_cnt_r + 17'h00001;
        end
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        per_cnt_r <= 17'h00000;
    end else begin
        per_cnt_r <= per_cnt_nxt;
    end
end

// ----------------------------------------------------------------
// External waveform
// ----------------------------------------------------------------
reg pulse_r;
reg sq_r;
wire pulse_nxt;
// pulse lasts one tick, half the minimum period
assign pulse_nxt = timeout_evt ? 1'b1 : (src_tick ? 1'b0 : pulse_r);
// The pin is registered, so it lags the time-out by one bus cycle,
// and both waveforms drop together when feature-enable clears.

// Pulse and square wave state, output gating
always @(posedge aclk) begin
    if (!aresetn) begin
        pulse_r <= 1'b0;
        sq_r <= 1'b0;
        ext_wave_pin <= 1'b0;
    end else begin
        pulse_r <= feature_enable_r & pulse_nxt;
        sq_r <= feature_enable_r & (sq_r ^ timeout_evt);
        ext_wave_pin <= ext_output_enable_r & feature_enable_r &
                        (ext_wave_select_r ? (sq_r ^ timeout_evt) : pulse_nxt);
    end
end

// ----------------------------------------------------------------
// AXI4-Lite write channel
// ----------------------------------------------------------------
reg aw_have_r;
reg w_have_r;
reg [11:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
wire do_write;
wire b0;
assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
assign b0 = w_strb_r[0];
// Each ready rises for one cycle only, so a held request is taken once.

// Address and data capture, response
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        aw_addr_r <= 12'h000;
        w_data_r <= 32'h00000000;
        w_strb_r <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PWT_RESP_OKAY;
    end else begin
        s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_r)
                `PWT_OFF_CTRL, `PWT_OFF_RATEH, `PWT_OFF_RATEL, `PWT_OFF_TRIM, `PWT_OFF_STAT, `PWT_OFF_MASK: begin
                    s_axi_bresp <= `PWT_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `PWT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// AXI4-Lite read channel
// ----------------------------------------------------------------
reg [7:0] rd_byte;
wire rd_take;
assign rd_take = s_axi_arvalid & s_axi_arready;
// The address is decoded at the handshake edge, so it must stand until arready.

// Read mux
always @* begin
    case (s_axi_araddr)
        `PWT_OFF_CTRL: rd_byte = {timer_clock_select_r, 2'b00, ext_wave_select_r, ext_output_enable_r,
                                  feature_enable_r, irq_enable_r, timeout_flag_r};
        `PWT_OFF_RATEH: rd_byte = rate_value_r[15:8];
        `PWT_OFF_RATEL: rd_byte = rate_value_r[7:0];
        `PWT_OFF_TRIM: rd_byte = {period_trim_field_r, 2'b00};
        `PWT_OFF_STAT: rd_byte = {6'h00, evt_status_r};
        `PWT_OFF_MASK: rd_byte = {6'h00, evt_mask_r};
        default: rd_byte = 8'h00;
    endcase
end

// Read handshake and response
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PWT_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            case (s_axi_araddr)
                `PWT_OFF_CTRL, `PWT_OFF_RATEH, `PWT_OFF_RATEL, `PWT_OFF_TRIM, `PWT_OFF_STAT, `PWT_OFF_MASK: begin
                    s_axi_rresp <= `PWT_RESP_OKAY;
                end
                default: begin
                    s_axi_rresp <= `PWT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Register writes and flags
// ----------------------------------------------------------------
wire wr_ctrl;
wire wr_trim;
wire rd_stat;
assign wr_ctrl = do_write & b0 & (aw_addr_r == `PWT_OFF_CTRL);
assign wr_trim = do_write & b0 & (aw_addr_r == `PWT_OFF_TRIM);
assign rd_stat = rd_take & (s_axi_araddr == `PWT_OFF_STAT);

// Control, rate, trim, status and mask registers
always @(posedge aclk) begin
    if (!aresetn) begin
        timer_clock_select_r <= 1'b0;
        ext_wave_select_r <= 1'b0;
        ext_output_enable_r <= 1'b0;
        feature_enable_r <= 1'b0;
        irq_enable_r <= 1'b0;
        timeout_flag_r <= 1'b0;
        rate_value_r <= {`PWT_RST_RATE, `PWT_RST_RATE};
        period_trim_field_r <= `PWT_RST_TRIM;
        trim_loaded_r <= 1'b0;
        evt_status_r <= 2'b00;
        evt_mask_r <= 2'b00;
        irq <= 1'b0;
    end else begin
        // One-shot flag, so the trim loads once per reset release
        trim_loaded_r <= 1'b1;
        if (!trim_loaded_r) begin
            period_trim_field_r <= nvm_trim;
        end else if (wr_trim) begin
            period_trim_field_r <= w_data_r[7:`PWT_TRIM_LSB];
        end
        if (wr_ctrl) begin
            ext_wave_select_r <= w_data_r[`PWT_CTL_WAVESEL];
            ext_output_enable_r <= w_data_r[`PWT_CTL_EXTEN];
            feature_enable_r <= w_data_r[`PWT_CTL_FE];
            irq_enable_r <= w_data_r[`PWT_CTL_IE];
            // Holding the source while running keeps a period from mixing clocks
            // locked while enabled or being enabled
            if (!feature_enable_r && !w_data_r[`PWT_CTL_FE]) begin
                timer_clock_select_r <= w_data_r[`PWT_CTL_CLKSEL];
            end
        end
        // Rate bytes are written separately; software sets both before enabling
        // rate locked while enabled
        if (do_write && b0 && !feature_enable_r && aw_addr_r == `PWT_OFF_RATEH) begin
            rate_value_r[15:8] <= w_data_r[7:0];
        end
        if (do_write && b0 && !feature_enable_r && aw_addr_r == `PWT_OFF_RATEL) begin
            rate_value_r[7:0] <= w_data_r[7:0];
        end
        if (timeout_evt) begin
            timeout_flag_r <= 1'b1;
        end else if (wr_ctrl && w_data_r[`PWT_CTL_FLAG]) begin
            timeout_flag_r <= 1'b0;
        end
        // Mask gates only the status path, never the flag path
        if (do_write && b0 && aw_addr_r == `PWT_OFF_MASK) begin
            evt_mask_r <= w_data_r[1:0];
        end
        // Sticky events cleared by status read, new events win
        evt_status_r <= (rd_stat ? 2'b00 : evt_status_r) | {timeout_evt & ~timer_clock_select_r, timeout_evt};
        irq <= (irq_enable_r & timeout_flag_r) | |(evt_status_r & evt_mask_r);
    end
end

endmodule

// >>> tb/pwt_assertions.sv
`timescale 1ns/10ps
`include "pwt_defines.vh"
// ----
// Bus answer checker
// ----
module pwt_checker (
    input wire aclk, // Bus clock
    input wire aresetn, // Reset, active low
    input wire s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire [1:0] s_axi_bresp, // Write response
    input wire s_axi_bvalid, // Response valid
    input wire s_axi_bready, // Response ready
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire [1:0] s_axi_rresp, // Read response
    input wire s_axi_rvalid, // Read valid
    input wire s_axi_rready // Read ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Handshakes that start an answer
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_w_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence
    chk_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_w_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `PWT_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
    chk_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0)
        else $error("bad write response");
    chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready too long");
    chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready too long");
endmodule

// >>> tb/pwt_periodic_wakeup_timer_bench.sv
`timescale 1ns/10ps
`include "pwt_defines.vh"
// ----
// Timer bench
// ----
module pwt_periodic_wakeup_timer_bench;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic [5:0] nvm = 6'h00;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0;
    wire awr, wrd, bv, arr, rv, irq, pin;
    wire [1:0] brsp, rrsp;
    wire [31:0] rdat;
    logic [33:0] expq[$];
    int n_errors = 0, checks_done = 0;
    // Bus clock, 100 ns period
    always #50 aclk = ~aclk;
    pwt_periodic_wakeup_timer #(.ACLK_BASE(4), .ACLK_STEP(0)) dut (.aclk(aclk), .aresetn(aresetn), .nvm_trim(nvm),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brsp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrsp),
        .s_axi_rvalid(rv), .s_axi_rready(rrdy), .irq(irq), .ext_wave_pin(pin));
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Write one byte register, both channels offered together
    task automatic wr(input [11:0] a, input [7:0] d, output logic [1:0] r);
        logic ta, tw;
        ta = 0;
        tw = 0;
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1;
        wv <= 1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (awr) ta = 1;
            if (wrd) tw = 1;
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        brdy <= 1;
        @(posedge aclk);
        while (!bv) @(posedge aclk);
        r = brsp;
        brdy <= 0;
    endtask
    // Read one register, expectation noted for the monitor
    task automatic rd(input [11:0] a, input [7:0] d, input [1:0] e = `PWT_RESP_OKAY);
        expq.push_back({e, 24'h0, d});
        ara <= a;
        arv <= 1;
        @(posedge aclk);
        while (!arr) @(posedge aclk);
        arv <= 0;
        rrdy <= 1;
        @(posedge aclk);
        while (!rv) @(posedge aclk);
        rrdy <= 0;
    endtask
    // Count edges until the pin shows a level
    task automatic pin_wait(input logic lv, output int n);
        n = 0;
        while (pin !== lv && n < 5000) begin
            @(posedge aclk);
            n++;
        end
    endtask
    // Compare each read answer with the oldest note
    always @(posedge aclk) begin
        if (rv && rrdy) check({rrsp, rdat}, expq.pop_front());
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        complete_run;
    end
    // Main sequence
    initial begin
        logic [1:0] r;
        logic [7:0] t, sel;
        logic seen;
        int n, a, b, tk;
        void'($urandom(38));
        @(posedge aclk);
        nvm <= $urandom;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(`PWT_OFF_CTRL, 8'h00);
        rd(`PWT_OFF_RATEL, 8'h00);
        rd(`PWT_OFF_TRIM, {nvm, 2'b00});
        rd(12'h020, 8'h00, `PWT_RESP_SLVERR);
        wr(12'h020, 8'h5a, r);
        check(r, `PWT_RESP_SLVERR);
        t = $urandom;
        wr(`PWT_OFF_TRIM, t, r);
        rd(`PWT_OFF_TRIM, {t[7:2], 2'b00});
        wr(`PWT_OFF_RATEH, 8'hff, r);
        wr(`PWT_OFF_CTRL, 8'h84, r);
        rd(`PWT_OFF_CTRL, 8'h04);
        wr(`PWT_OFF_RATEL, 8'h33, r);
        rd(`PWT_OFF_RATEL, 8'h00);
        wr(`PWT_OFF_CTRL, 8'h00, r);
        rd(`PWT_OFF_RATEH, 8'hff);
        for (int i = 0; i < 4; i++) begin
            sel = (i < 2) ? 8'h80 : 8'h00;
            tk = (i < 2) ? 1 : 4;
            n = i[0] ? $urandom_range(12, 1) : 0;
            wr(`PWT_OFF_CTRL, sel, r);
            wr(`PWT_OFF_RATEH, 8'h00, r);
            wr(`PWT_OFF_RATEL, n[7:0], r);
            wr(`PWT_OFF_CTRL, sel | 8'h0e, r);
            pin_wait(1, a);
            pin_wait(0, a);
            pin_wait(1, b);
            check(a, tk);
            check(a + b, 2 * (n + 1) * tk);
            check(irq, 1);
            rd(`PWT_OFF_CTRL, sel | 8'h0f);
            wr(`PWT_OFF_CTRL, sel | 8'h1e, r);
            pin_wait(0, a);
            pin_wait(1, a);
            pin_wait(0, a);
            check(a, 2 * (n + 1) * tk);
            wr(`PWT_OFF_CTRL, sel | 8'h18, r);
            repeat (2) @(posedge aclk);
            check(pin, 0);
            check(irq, 0);
            rd(`PWT_OFF_CTRL, sel | 8'h19);
            wr(`PWT_OFF_CTRL, sel | 8'h01, r);
            rd(`PWT_OFF_CTRL, sel);
        end
        wr(`PWT_OFF_MASK, 8'h01, r);
        rd(`PWT_OFF_STAT, 8'h03);
        rd(`PWT_OFF_STAT, 8'h00);
        wr(`PWT_OFF_CTRL, 8'h04, r);
        seen = 0;
        repeat (300) begin
            @(posedge aclk);
            seen = seen | pin;
        end
        check(seen, 0);
        check(irq, 1);
        wr(`PWT_OFF_CTRL, 8'h00, r);
        rd(`PWT_OFF_STAT, 8'h03);
        wr(`PWT_OFF_MASK, 8'h00, r);
        wr(`PWT_OFF_CTRL, 8'h04, r);
        repeat (300) @(posedge aclk);
        check(irq, 0);
        complete_run;
    end
endmodule
bind pwt_periodic_wakeup_timer pwt_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
